// ### hw/rrsb_pkg.sv
// shared types and constants for the rotate and subtract datapath
package rrsb_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROTATE_RIGHT_MEM = 3'h1,
    OP_ROTATE_RIGHT_TO_ACC = 3'h2,
    OP_ROTATE_RIGHT_CARRY_MEM = 3'h3,
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 3'h4,
    OP_SUB_BORROW_TO_ACC = 3'h5,
    OP_SUB_BORROW_TO_MEM = 3'h6
  } op_type;

  typedef struct packed {
    logic signed_compare_flag;
    logic chained_zero_flag;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } flags_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [7:0] mem_data;
  } req_type;

  typedef struct packed {
    logic mem_we;
    logic [7:0] mem_wdata;
  } mem_wr_type;
endpackage

// ### hw/rrsb_alu.sv
// rotate-right and subtract-with-borrow datapath slice
// Contract
// - memory rotate right, bit0 to bit7, no flags
// - same rotate into accumulator, memory untouched
// - carry ring rotate right, result to memory
// - carry ring rotate into accumulator, carry only
// - accumulator minus operand minus inverted carry
// - carry clear on borrow, set otherwise
// - subtract updates all six flags
// - memory variant writes difference to memory
`timescale 1ns/100ps
module rrsb_alu (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire rrsb_pkg::req_type REQ,
  output rrsb_pkg::mem_wr_type MEM_WR,
  output logic [7:0] ACC,
  output rrsb_pkg::flags_type FLAGS
);
  import rrsb_pkg::*;

  typedef struct packed {
    mem_wr_type wr;
    logic [7:0] acc;
    flags_type flags;
  } state_type;

  state_type state;
  state_type next_state;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] rot;
  logic [7:0] rot_c;

  always_comb begin
    rot = {REQ.mem_data[0], REQ.mem_data[7:1]};
    rot_c = {state.flags.c, REQ.mem_data[7:1]};
    diff = {1'b0, state.acc} - {1'b0, REQ.mem_data} - {8'h00, ~state.flags.c};
    low_diff = {1'b0, state.acc[3:0]} - {1'b0, REQ.mem_data[3:0]} - {4'h0, ~state.flags.c};
    next_state = state;
    next_state.wr.mem_we = 1'b0;
    if (REQ.valid) begin
      unique case (REQ.op)
        OP_ROTATE_RIGHT_MEM: begin
          next_state.wr = '{mem_we: 1'b1, mem_wdata: rot};
        end
        OP_ROTATE_RIGHT_TO_ACC: begin
          next_state.acc = rot;
        end
        OP_ROTATE_RIGHT_CARRY_MEM: begin
          next_state.wr = '{mem_we: 1'b1, mem_wdata: rot_c};
          next_state.flags.c = REQ.mem_data[0];
        end
        OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
          next_state.acc = rot_c;
          next_state.flags.c = REQ.mem_data[0];
        end
        OP_SUB_BORROW_TO_ACC, OP_SUB_BORROW_TO_MEM: begin
          if (REQ.op == OP_SUB_BORROW_TO_ACC) begin
            next_state.acc = diff[7:0];
          end else begin
            next_state.wr = '{mem_we: 1'b1, mem_wdata: diff[7:0]};
          end
          next_state.flags.c = ~diff[8];
          next_state.flags.ac = ~low_diff[4];
          next_state.flags.z = (diff[7:0] == 8'h00);
          next_state.flags.ov = (state.acc[7] ^ REQ.mem_data[7]) & (state.acc[7] ^ diff[7]);
          next_state.flags.signed_compare_flag = diff[7] ^ next_state.flags.ov;
          next_state.flags.chained_zero_flag = state.flags.chained_zero_flag & (diff[7:0] == 8'h00);
        end
        default: begin
          next_state.wr.mem_we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= '{wr: '{mem_we: 1'b0, mem_wdata: 8'h00}, acc: ACC_RESET, flags: flags_type'(FLAGS_RESET)};
    end else begin
      state <= next_state;
    end
  end

  assign MEM_WR = state.wr;
  assign ACC = state.acc;
  assign FLAGS = state.flags;

  // rotates: result placement and untouched state
  property p_rot_mem;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_MEM |=>
      MEM_WR.mem_we && MEM_WR.mem_wdata == {$past(REQ.mem_data[0]), $past(REQ.mem_data[7:1])} && $stable(FLAGS);
  endproperty
  a_rot_mem: assert property (p_rot_mem) else $error("rotate to memory wrong");

  property p_rot_mem_keep;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_MEM |=> $stable(ACC);
  endproperty
  a_rot_mem_keep: assert property (p_rot_mem_keep) else $error("rotate to memory touched accumulator");

  property p_rot_acc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_TO_ACC |=>
      !MEM_WR.mem_we && ACC == {$past(REQ.mem_data[0]), $past(REQ.mem_data[7:1])} && $stable(FLAGS);
  endproperty
  a_rot_acc: assert property (p_rot_acc) else $error("rotate to accumulator wrong");

  // a write pulse only ever follows a memory-writing op
  property p_we_only_mem;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    MEM_WR.mem_we |->
      $past(REQ.valid) && ($past(REQ.op) == OP_ROTATE_RIGHT_MEM || $past(REQ.op) == OP_ROTATE_RIGHT_CARRY_MEM ||
      $past(REQ.op) == OP_SUB_BORROW_TO_MEM);
  endproperty
  a_we_only_mem: assert property (p_we_only_mem) else $error("memory written by a non-memory op");

  property p_rotc_mem;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_CARRY_MEM |=>
      MEM_WR.mem_we && MEM_WR.mem_wdata[7] == $past(FLAGS.c) && FLAGS.c == $past(REQ.mem_data[0]);
  endproperty
  a_rotc_mem: assert property (p_rotc_mem) else $error("carry rotate to memory wrong");

  property p_rotc_mem_rest;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_CARRY_MEM |=>
      MEM_WR.mem_wdata[6:0] == $past(REQ.mem_data[7:1]) && $stable(ACC) && FLAGS[5:1] == $past(FLAGS[5:1]);
  endproperty
  a_rotc_mem_rest: assert property (p_rotc_mem_rest) else $error("carry rotate to memory disturbed state");

  property p_rotc_acc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
      !MEM_WR.mem_we && ACC[7] == $past(FLAGS.c) && FLAGS.c == $past(REQ.mem_data[0]) && FLAGS.z == $past(FLAGS.z);
  endproperty
  a_rotc_acc: assert property (p_rotc_acc) else $error("carry rotate to accumulator wrong");

  property p_rotc_acc_rest;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
      ACC[6:0] == $past(REQ.mem_data[7:1]) && FLAGS[5:1] == $past(FLAGS[5:1]);
  endproperty
  a_rotc_acc_rest: assert property (p_rotc_acc_rest) else $error("carry rotate to accumulator low bits wrong");

  // subtract: result, destination and every flag
  property p_sub_acc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_ACC |=>
      ACC == 8'($past(ACC) - $past(REQ.mem_data) - {7'h00, ~$past(FLAGS.c)});
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract to accumulator wrong");

  property p_sub_acc_nowrite;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_ACC |=> !MEM_WR.mem_we;
  endproperty
  a_sub_acc_nowrite: assert property (p_sub_acc_nowrite) else $error("subtract to accumulator wrote memory");

  // carry is set exactly when acc covers operand plus borrow-in
  property p_sub_carry;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && (REQ.op == OP_SUB_BORROW_TO_ACC || REQ.op == OP_SUB_BORROW_TO_MEM) |=>
      FLAGS.c == ({1'b0, $past(ACC)} >= {1'b0, $past(REQ.mem_data)} + {8'h00, !$past(FLAGS.c)});
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("borrow not shown in carry");

  property p_sub_ac;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && (REQ.op == OP_SUB_BORROW_TO_ACC || REQ.op == OP_SUB_BORROW_TO_MEM) |=>
      FLAGS.ac == ({1'b0, $past(ACC[3:0])} >= {1'b0, $past(REQ.mem_data[3:0])} + {4'h0, !$past(FLAGS.c)});
  endproperty
  a_sub_ac: assert property (p_sub_ac) else $error("half borrow flag wrong");

  property p_sub_cz;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && (REQ.op == OP_SUB_BORROW_TO_ACC || REQ.op == OP_SUB_BORROW_TO_MEM) |=>
      FLAGS.chained_zero_flag == ($past(FLAGS.chained_zero_flag) && FLAGS.z);
  endproperty
  a_sub_cz: assert property (p_sub_cz) else $error("chained zero flag wrong");

  property p_sub_sc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_ACC |=> FLAGS.signed_compare_flag == (FLAGS.ov ^ ACC[7]);
  endproperty
  a_sub_sc: assert property (p_sub_sc) else $error("signed compare flag wrong");

  property p_sub_mem_sc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_MEM |=> FLAGS.signed_compare_flag == (FLAGS.ov ^ MEM_WR.mem_wdata[7]);
  endproperty
  a_sub_mem_sc: assert property (p_sub_mem_sc) else $error("signed compare flag wrong after memory subtract");

  property p_sub_mem;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_MEM |=> MEM_WR.mem_we && $stable(ACC);
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");

  property p_sub_mem_data;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_MEM |=>
      MEM_WR.mem_wdata == 8'($past(ACC) - $past(REQ.mem_data) - {7'h00, !$past(FLAGS.c)});
  endproperty
  a_sub_mem_data: assert property (p_sub_mem_data) else $error("difference written to memory wrong");

  // zero result can still carry a borrow: 00 - FF - 1
  property p_sub_zero;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_MEM |=> FLAGS.z == (MEM_WR.mem_wdata == 8'h00);
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("zero flag wrong");

  property p_sub_acc_zero;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_ACC |=> FLAGS.z == (ACC == 8'h00);
  endproperty
  a_sub_acc_zero: assert property (p_sub_acc_zero) else $error("zero flag wrong after accumulator subtract");

  property p_sub_ov_acc;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_ACC |=>
      FLAGS.ov == (($past(ACC[7]) != $past(REQ.mem_data[7])) && ($past(ACC[7]) != ACC[7]));
  endproperty
  a_sub_ov_acc: assert property (p_sub_ov_acc) else $error("overflow flag wrong");

  property p_sub_ov_mem;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REQ.valid && REQ.op == OP_SUB_BORROW_TO_MEM |=>
      FLAGS.ov == (($past(ACC[7]) != $past(REQ.mem_data[7])) && ($past(ACC[7]) != MEM_WR.mem_wdata[7]));
  endproperty
  a_sub_ov_mem: assert property (p_sub_ov_mem) else $error("overflow flag wrong after memory subtract");
endmodule

// ### sim/rrsb_alu_tb.sv
// self-checking bench for the rotate and subtract datapath
`timescale 1ns/100ps
module rotate_right_subtract_borrow_alu_tb;
  import rrsb_pkg::*;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  req_type REQ = '0;
  mem_wr_type MEM_WR;
  logic [7:0] ACC;
  flags_type FLAGS;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] e_acc = ACC_RESET;
  flags_type e_fl = FLAGS_RESET;
  rrsb_alu dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REQ(REQ), .MEM_WR(MEM_WR), .ACC(ACC), .FLAGS(FLAGS));
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // model first, then issue; sample 1 ns after the answering edge
  task automatic step(op_type o, logic [7:0] m);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] r;
    logic cr;
    logic we;
    cr = (o == OP_ROTATE_RIGHT_CARRY_MEM || o == OP_ROTATE_RIGHT_CARRY_TO_ACC);
    d = {1'b0, e_acc} - {1'b0, m} - {8'h00, ~e_fl.c};
    n = {1'b0, e_acc[3:0]} - {1'b0, m[3:0]} - {4'h0, ~e_fl.c};
    r = cr ? {e_fl.c, m[7:1]} : {m[0], m[7:1]};
    we = (o == OP_ROTATE_RIGHT_MEM || o == OP_ROTATE_RIGHT_CARRY_MEM || o == OP_SUB_BORROW_TO_MEM);
    if (cr)
      e_fl.c = m[0];
    if (o == OP_SUB_BORROW_TO_ACC || o == OP_SUB_BORROW_TO_MEM) begin
      r = d[7:0];
      e_fl.c = ~d[8];
      e_fl.z = (r == 8'h00);
      e_fl.ov = (e_acc[7] != m[7]) && (r[7] != e_acc[7]);
      e_fl.ac = ~n[4];
      e_fl.signed_compare_flag = r[7] ^ e_fl.ov;
      e_fl.chained_zero_flag = e_fl.chained_zero_flag & e_fl.z;
    end
    if (o == OP_ROTATE_RIGHT_TO_ACC || o == OP_ROTATE_RIGHT_CARRY_TO_ACC || o == OP_SUB_BORROW_TO_ACC)
      e_acc = r;
    @(posedge SYS_CLK);
    REQ <= '{1'b1, o, m};
    @(posedge SYS_CLK);
    REQ <= '0;
    #1;
    chk_byte(ACC, e_acc, "acc");
    chk_byte({2'b00, FLAGS}, {2'b00, e_fl}, "flags");
    chk_byte({7'h00, MEM_WR.mem_we}, {7'h00, we}, "write strobe");
    if (we)
      chk_byte(MEM_WR.mem_wdata, r, "write data");
  endtask
  task automatic t_rotate();
    step(OP_ROTATE_RIGHT_MEM, 8'h81);
    step(OP_ROTATE_RIGHT_TO_ACC, 8'h01);
    step(OP_ROTATE_RIGHT_CARRY_MEM, 8'h03);
    step(OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h02);
    step(OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h00);
  endtask
  // borrow, zero, overflow and half borrow edges
  task automatic t_sub();
    step(OP_SUB_BORROW_TO_MEM, 8'hFF);
    step(OP_SUB_BORROW_TO_ACC, 8'h00);
    step(OP_SUB_BORROW_TO_ACC, 8'h81);
    step(OP_SUB_BORROW_TO_ACC, 8'h01);
    step(OP_SUB_BORROW_TO_MEM, 8'h7E);
    step(OP_ROTATE_RIGHT_TO_ACC, 8'h01);
    step(OP_SUB_BORROW_TO_MEM, 8'h01);
    step(OP_SUB_BORROW_TO_ACC, 8'h80);
  endtask
  task automatic t_idle();
    step(OP_NONE, 8'h55);
    step(op_type'(3'h7), 8'hAA);
  endtask
  // mid-run reset clears accumulator, flags and write data
  task automatic t_reset();
    step(OP_ROTATE_RIGHT_TO_ACC, 8'h01);
    @(posedge SYS_CLK);
    ARST_N <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk_byte(ACC, ACC_RESET, "mid reset acc");
    chk_byte({2'b00, FLAGS}, {2'b00, FLAGS_RESET}, "mid reset flags");
    chk_byte(MEM_WR.mem_wdata, 8'h00, "mid reset write data");
    @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    e_acc = ACC_RESET;
    e_fl = FLAGS_RESET;
  endtask
  // back to back from the reset state: second op sees first op's carry
  task automatic t_chain();
    @(posedge SYS_CLK);
    REQ <= '{1'b1, OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h03};
    @(posedge SYS_CLK);
    REQ <= '{1'b1, OP_SUB_BORROW_TO_ACC, 8'h01};
    #1;
    chk_byte(ACC, 8'h01, "chain first acc");
    chk_byte({2'b00, FLAGS}, 8'h01, "chain first flags");
    @(posedge SYS_CLK);
    REQ <= '0;
    #1;
    chk_byte(ACC, 8'h00, "chain second acc");
    chk_byte({2'b00, FLAGS}, 8'h07, "chain second flags");
    e_acc = 8'h00;
    e_fl = flags_type'(6'h07);
  endtask
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    #1;
    chk_byte(ACC, ACC_RESET, "reset acc");
    chk_byte({2'b00, FLAGS}, {2'b00, FLAGS_RESET}, "reset flags");
    t_rotate();
    t_sub();
    t_idle();
    t_reset();
    t_chain();
    complete_run();
  end
endmodule
